/* File: src/fbs_pkg.sv */
/*
  fbs_pkg: shared constants of the fan boost hysteresis and spike smoothing block.
  Register indices, field positions, reset values and filter timing.
  Assumes a 250 MHz system clock; every byte address is four times the index.
*/
package fbs_pkg;

  // clock rate and register decode
  localparam int         CLK_MHZ            = 250;
  localparam int         IDX_W              = 8;
  localparam logic [7:0] IDX_HYST_AB        = 8'hC0;
  localparam logic [7:0] IDX_HYST_CD        = 8'hC1;
  localparam logic [7:0] IDX_SMOOTH_CTRL    = 8'hC2;
  localparam logic [7:0] IDX_FILT_TEMP_A    = 8'hE0;
  localparam logic [7:0] IDX_FILT_TEMP_B    = 8'hE1;
  localparam logic [7:0] IDX_RAW_TEMP_A     = 8'hE2;
  localparam logic [7:0] IDX_RAW_TEMP_B     = 8'hE3;
  localparam logic [7:0] IDX_BOOST_STAT     = 8'hE4;
  localparam logic [7:0] IDX_BOOST_TEMP_A   = 8'hE8;
  localparam logic [7:0] IDX_BOOST_TEMP_B   = 8'hE9;
  localparam logic [7:0] IDX_BOOST_TEMP_C   = 8'hEA;
  localparam logic [7:0] IDX_BOOST_TEMP_D   = 8'hEB;

  // reset values
  localparam logic [7:0] HYST_RST           = 8'h00;
  localparam logic [7:0] SMOOTH_CTRL_RST    = 8'h00;
  localparam logic [7:0] BOOST_TEMP_RST     = 8'h7F;
  localparam logic [7:0] TEMP_RST           = 8'h00;

  // field positions
  localparam int         HYST_LO_LSB        = 0;
  localparam int         HYST_HI_LSB        = 4;
  localparam int         SEL_A_LSB          = 0;
  localparam int         EN_A_BIT           = 3;
  localparam int         SEL_B_LSB          = 4;
  localparam int         EN_B_BIT           = 7;

  // filter timing: spans in tenths of a second, one step each 1/16 of a span
  localparam int         SPAN_UNIT_MS       = 100;
  localparam int         FILT_SHIFT         = 4;
  localparam int         BASE_STEP_CYCLES   = SPAN_UNIT_MS * CLK_MHZ * 1000 / (1 << FILT_SHIFT);
  localparam logic [6:0] SPAN_UNITS [8]     = '{7'h76, 7'h46, 7'h2C, 7'h1E, 7'h10, 7'h08, 7'h06, 7'h04};

endpackage : fbs_pkg

/* File: src/fbs_spike_filter.sv */
/*
  fbs_spike_filter: one zone of the temperature spike smoothing filter.
  Assumes samples and the base tick come from logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

module fbs_spike_filter #(
  parameter int TEMP_W = 8
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              srst,
  // control
  input  wire logic              base_tick,
  input  wire logic [2:0]        smooth_sel,
  // converted samples
  input  wire logic              sample_valid,
  input  wire logic [TEMP_W-1:0] sample,
  // smoothed result
  output logic      [TEMP_W-1:0] filt_temp
);

  localparam int ACC_W = TEMP_W + fbs_pkg::FILT_SHIFT;

  logic [6:0]        span_cnt_reg;
  logic [TEMP_W-1:0] hold_reg;
  logic [ACC_W-1:0]  acc_reg;
  logic              primed_reg;
  wire  [6:0]        span_len;
  wire               step;
  wire  [ACC_W:0]    diff;
  wire  [ACC_W:0]    acc_next;

  // span length per selector; the step rate sets the time constant
  assign span_len  = fbs_pkg::SPAN_UNITS[smooth_sel];
  assign step      = base_tick & primed_reg & (span_cnt_reg + 7'h01 >= span_len);
  assign diff      = {hold_reg[TEMP_W-1], hold_reg, {fbs_pkg::FILT_SHIFT{1'b0}}} -
                     {acc_reg[ACC_W-1], acc_reg};
  // both addends signed: an unsigned one would make the shift logical on a falling input
  assign acc_next  = $signed({acc_reg[ACC_W-1], acc_reg}) + ($signed(diff) >>> fbs_pkg::FILT_SHIFT);
  assign filt_temp = acc_reg[ACC_W-1 -: TEMP_W];

  // first-order low pass on top of the converter's own averaging
  always_ff @(posedge clock) begin
    if (srst) begin
      span_cnt_reg <= 7'h00;
      hold_reg     <= '0;
      acc_reg      <= '0;
      primed_reg   <= 1'b0;
    end else begin
      if (sample_valid) begin
        hold_reg <= sample;
      end
      if (sample_valid & ~primed_reg) begin
        acc_reg    <= {sample, {fbs_pkg::FILT_SHIFT{1'b0}}};             // start at first sample
        primed_reg <= 1'b1;
      end else if (step) begin
        acc_reg <= acc_next[ACC_W-1:0];
      end
      if (step) begin
        span_cnt_reg <= 7'h00;
      end else if (base_tick) begin
        span_cnt_reg <= span_cnt_reg + 7'h01;
      end
    end
  end

endmodule // fbs_spike_filter

`default_nettype wire

/* File: src/fbs_boost_hyst.sv */
/*
  fbs_boost_hyst: per-zone fan boost state with release hysteresis.
  Assumes signed temperatures in whole degrees and a one-cycle evaluate strobe.
*/
`timescale 1ns/100ps
`default_nettype none

module fbs_boost_hyst #(
  parameter int ZONES  = 4,
  parameter int TEMP_W = 8,
  parameter int HYST_W = 4
) (
  // clock and reset
  input  wire logic                         clock,
  input  wire logic                         srst,
  // evaluation inputs
  input  wire logic                         eval,
  input  wire logic [ZONES-1:0][TEMP_W-1:0] zone_temp,
  input  wire logic [ZONES-1:0][TEMP_W-1:0] boost_temp,
  input  wire logic [ZONES-1:0][HYST_W-1:0] boost_hyst,
  // full duty requests
  output logic      [ZONES-1:0]             full_duty
);

  genvar z;
  generate
    for (z = 0; z < ZONES; z++) begin : g_zone
      logic               boost_reg;
      wire  [TEMP_W+1:0]  t_ext;
      wire  [TEMP_W+1:0]  b_ext;
      wire  [TEMP_W+1:0]  release_lvl;
      wire                above;
      wire                below_rel;

      // unsigned hysteresis of 0..15 degrees under the boost point
      assign t_ext       = {{2{zone_temp[z][TEMP_W-1]}}, zone_temp[z]};
      assign b_ext       = {{2{boost_temp[z][TEMP_W-1]}}, boost_temp[z]};
      assign release_lvl = b_ext - {{(TEMP_W+2-HYST_W){1'b0}}, boost_hyst[z]};
      assign above       = $signed(t_ext) > $signed(b_ext);
      assign below_rel   = $signed(t_ext) < $signed(release_lvl);
      assign full_duty[z] = boost_reg;

      // boost holds through the band between the point and the release level
      always_ff @(posedge clock) begin
        if (srst) begin
          boost_reg <= 1'b0;
        end else if (eval) begin
          if (above) begin
            boost_reg <= 1'b1;
          end else if (boost_reg & below_rel) begin
            boost_reg <= 1'b0;
          end
        end
      end
    end
  endgenerate

endmodule // fbs_boost_hyst

`default_nettype wire

/* File: src/fbs_fan_boost_smooth.sv */
/*
  fbs_fan_boost_smooth: boost hysteresis and zone a/b spike smoothing, with an
  Avalon-MM register slave (32-bit data, byte address, one wait state).
  Assumes temperature samples arrive on the same clock with a one-cycle valid.
*/
`timescale 1ns/100ps
`default_nettype none

// How it works
// - hyst byte C0 holds zones a, b
// - hyst byte C1 holds zones c, d
// - full duty held until hysteresis below
// - hysteresis is unsigned 0 to 15 degrees
// - bits 2:0 select zone a smoothing, reset zero
// - bit 3 feeds filtered zone a onward
// - bit 7 feeds filtered zone b onward
// - enable clear feeds raw temperature onward
// - filtered temperature always readable
// - raw reading registers stay unfiltered
// - filter works on converted samples
// - selector codes map to eight spans
module fbs_fan_boost_smooth #(
  parameter int BASE_STEP_CYCLES = fbs_pkg::BASE_STEP_CYCLES,
  parameter int TEMP_W           = 8,
  parameter int HYST_W           = 4
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              srst,
  // avalon-mm register slave
  input  wire logic [9:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  // converted temperatures
  input  wire logic              temp_valid,
  input  wire logic [TEMP_W-1:0] temp_zone_a,
  input  wire logic [TEMP_W-1:0] temp_zone_b,
  input  wire logic [TEMP_W-1:0] temp_zone_c,
  input  wire logic [TEMP_W-1:0] temp_zone_d,
  // temperatures for limit checking and fan control
  output logic                   ctrl_temp_valid,
  output logic      [TEMP_W-1:0] ctrl_temp_zone_a,
  output logic      [TEMP_W-1:0] ctrl_temp_zone_b,
  // full duty requests per zone
  output logic      [3:0]        pwm_full_duty
);

  localparam int ZONES = 4;
  localparam int PRE_W = $clog2(BASE_STEP_CYCLES + 1);
  // the prescaler width follows the parameter, so a shortened simulation step
  // leaves at most one unused high bit behind

  // all software-written state sits in this module; the submodules hold the
  // filter accumulators, sample holds, span counters and boost flags
  // register state
  logic [7:0]              hyst_ab_reg;
  logic [7:0]              hyst_cd_reg;
  logic [7:0]              smooth_ctrl_reg;
  logic [ZONES-1:0][7:0]   boost_temp_reg;
  logic [TEMP_W-1:0]       raw_a_reg;
  logic [TEMP_W-1:0]       raw_b_reg;
  logic [TEMP_W-1:0]       raw_c_reg;
  logic [TEMP_W-1:0]       raw_d_reg;
  logic [31:0]             avs_readdata_reg;
  logic                    avs_waitrequest_reg;
  logic                    ctrl_valid_reg;
  logic [TEMP_W-1:0]       ctrl_a_reg;
  logic [TEMP_W-1:0]       ctrl_b_reg;
  logic [PRE_W-1:0]        pre_cnt_reg;
  logic                    base_tick_reg;
  logic                    eval_reg;

  // bus decode
  wire  [7:0]              reg_idx;
  wire                     bus_req;
  wire                     bus_take;
  wire                     wr_take;
  wire                     sel_hyst_ab;
  wire                     sel_hyst_cd;
  wire                     sel_smooth;
  wire  [ZONES-1:0]        sel_boost;
  wire  [7:0]              wr_byte;
  logic [7:0]              rd_byte;

  // filter and boost wiring
  wire  [2:0]              smooth_sel_zone_a;
  wire  [2:0]              smooth_sel_zone_b;
  wire                     smooth_en_zone_a;
  wire                     smooth_en_zone_b;
  wire  [HYST_W-1:0]       boost_hyst_zone_a;
  wire  [HYST_W-1:0]       boost_hyst_zone_b;
  wire  [HYST_W-1:0]       boost_hyst_zone_c;
  wire  [HYST_W-1:0]       boost_hyst_zone_d;
  wire  [TEMP_W-1:0]       filt_a;
  wire  [TEMP_W-1:0]       filt_b;
  wire  [TEMP_W-1:0]       sel_a;
  wire  [TEMP_W-1:0]       sel_b;
  wire  [3:0]              full_duty;

  // there is no byteenable: each register is one byte in bits 7:0 of its word,
  // so every accepted write replaces the whole byte
  // address decode; the two low address bits are ignored (word registers)
  assign reg_idx     = avs_address[9:2];
  assign bus_req     = avs_read | avs_write;
  assign bus_take    = bus_req & ~avs_waitrequest_reg;
  assign wr_take     = bus_take & avs_write;
  assign wr_byte     = avs_writedata[7:0];
  assign sel_hyst_ab = (reg_idx == fbs_pkg::IDX_HYST_AB);
  assign sel_hyst_cd = (reg_idx == fbs_pkg::IDX_HYST_CD);
  assign sel_smooth  = (reg_idx == fbs_pkg::IDX_SMOOTH_CTRL);
  assign sel_boost   = {reg_idx == fbs_pkg::IDX_BOOST_TEMP_D, reg_idx == fbs_pkg::IDX_BOOST_TEMP_C,
                        reg_idx == fbs_pkg::IDX_BOOST_TEMP_B, reg_idx == fbs_pkg::IDX_BOOST_TEMP_A};

  // selector and enable share one byte per zone pair; a new selector and an
  // enable change written together take effect on the same edge
  // field extraction from the control bytes
  assign boost_hyst_zone_a = hyst_ab_reg[fbs_pkg::HYST_LO_LSB +: HYST_W];
  assign boost_hyst_zone_b = hyst_ab_reg[fbs_pkg::HYST_HI_LSB +: HYST_W];
  assign boost_hyst_zone_c = hyst_cd_reg[fbs_pkg::HYST_LO_LSB +: HYST_W];
  assign boost_hyst_zone_d = hyst_cd_reg[fbs_pkg::HYST_HI_LSB +: HYST_W];
  assign smooth_sel_zone_a = smooth_ctrl_reg[fbs_pkg::SEL_A_LSB +: 3];
  assign smooth_sel_zone_b = smooth_ctrl_reg[fbs_pkg::SEL_B_LSB +: 3];
  assign smooth_en_zone_a  = smooth_ctrl_reg[fbs_pkg::EN_A_BIT];
  assign smooth_en_zone_b  = smooth_ctrl_reg[fbs_pkg::EN_B_BIT];

  // filtered or raw value onward, chosen per zone enable
  // the choice reaches the control outputs one cycle after the register write
  assign sel_a = smooth_en_zone_a ? filt_a : raw_a_reg;
  assign sel_b = smooth_en_zone_b ? filt_b : raw_b_reg;

  // filtered values read back without their four fraction bits, so a reading can
  // sit one degree under a steady input once the filter has settled
  // read mux; unmapped indices read as zero
  always_comb begin
    rd_byte = 8'h00;
    case (reg_idx)
      fbs_pkg::IDX_HYST_AB:      rd_byte = hyst_ab_reg;
      fbs_pkg::IDX_HYST_CD:      rd_byte = hyst_cd_reg;
      fbs_pkg::IDX_SMOOTH_CTRL:  rd_byte = smooth_ctrl_reg;
      fbs_pkg::IDX_FILT_TEMP_A:  rd_byte = filt_a;
      fbs_pkg::IDX_FILT_TEMP_B:  rd_byte = filt_b;
      fbs_pkg::IDX_RAW_TEMP_A:   rd_byte = raw_a_reg;
      fbs_pkg::IDX_RAW_TEMP_B:   rd_byte = raw_b_reg;
      fbs_pkg::IDX_BOOST_STAT:   rd_byte = {4'h0, full_duty};
      fbs_pkg::IDX_BOOST_TEMP_A: rd_byte = boost_temp_reg[0];
      fbs_pkg::IDX_BOOST_TEMP_B: rd_byte = boost_temp_reg[1];
      fbs_pkg::IDX_BOOST_TEMP_C: rd_byte = boost_temp_reg[2];
      fbs_pkg::IDX_BOOST_TEMP_D: rd_byte = boost_temp_reg[3];
      default:                   rd_byte = 8'h00;
    endcase
  end

  // every access costs two cycles; the fixed wait state lets the read mux land in
  // a register instead of driving the bus from a long combinational path
  // one wait state: waitrequest drops for exactly one cycle per request
  always_ff @(posedge clock) begin
    if (srst) begin
      avs_waitrequest_reg <= 1'b1;
      avs_readdata_reg    <= 32'h0000_0000;
    end else begin
      avs_waitrequest_reg <= ~(bus_req & avs_waitrequest_reg);
      if (avs_read & avs_waitrequest_reg) begin
        avs_readdata_reg <= {24'h00_0000, rd_byte};
      end
    end
  end

  // the hysteresis bytes start at zero: boost then releases right at the boost
  // point until software programs a band
  // software-written control bytes, written at the accepting edge only
  always_ff @(posedge clock) begin
    if (srst) begin
      hyst_ab_reg     <= fbs_pkg::HYST_RST;
      hyst_cd_reg     <= fbs_pkg::HYST_RST;
      smooth_ctrl_reg <= fbs_pkg::SMOOTH_CTRL_RST;
    end else if (wr_take) begin
      if (sel_hyst_ab) hyst_ab_reg <= wr_byte;
      if (sel_hyst_cd) hyst_cd_reg <= wr_byte;
      if (sel_smooth)  smooth_ctrl_reg <= wr_byte;
    end
  end

  // boost points, one byte per zone
  // 7F is the highest positive reading, so no zone boosts before software sets a point
  genvar z;
  generate
    for (z = 0; z < ZONES; z++) begin : g_bpt
      always_ff @(posedge clock) begin
        if (srst) begin
          boost_temp_reg[z] <= fbs_pkg::BOOST_TEMP_RST;
        end else if (wr_take & sel_boost[z]) begin
          boost_temp_reg[z] <= wr_byte;
        end
      end
    end
  endgenerate

  // reading registers always carry the latest unfiltered conversion
  // they never pass through the filter, whatever the enables say
  always_ff @(posedge clock) begin
    if (srst) begin
      raw_a_reg <= fbs_pkg::TEMP_RST;
      raw_b_reg <= fbs_pkg::TEMP_RST;
      raw_c_reg <= fbs_pkg::TEMP_RST;
      raw_d_reg <= fbs_pkg::TEMP_RST;
    end else if (temp_valid) begin
      raw_a_reg <= temp_zone_a;
      raw_b_reg <= temp_zone_b;
      raw_c_reg <= temp_zone_c;
      raw_d_reg <= temp_zone_d;
    end
  end

  // one prescaler serves both filters; a selector change takes effect at the
  // next base tick rather than restarting a span
  // shared prescaler: one tick per 1/16 of a span unit, counted in cycles
  always_ff @(posedge clock) begin
    if (srst) begin
      pre_cnt_reg   <= '0;
      base_tick_reg <= 1'b0;
    end else if (pre_cnt_reg == PRE_W'(BASE_STEP_CYCLES - 1)) begin
      pre_cnt_reg   <= '0;
      base_tick_reg <= 1'b1;
    end else begin
      pre_cnt_reg   <= pre_cnt_reg + PRE_W'(1);
      base_tick_reg <= 1'b0;
    end
  end

  // zone a and b smoothing run whether or not they are enabled
  // keeping them running leaves the filtered registers readable with the enable
  // clear, and setting the enable later switches to an already settled value
  fbs_spike_filter #(
    .TEMP_W       (TEMP_W)
  ) u_filt_a (
    .clock        (clock),
    .srst         (srst),
    .base_tick    (base_tick_reg),
    .smooth_sel   (smooth_sel_zone_a),
    .sample_valid (temp_valid),
    .sample       (temp_zone_a),
    .filt_temp    (filt_a)
  );

  fbs_spike_filter #(
    .TEMP_W       (TEMP_W)
  ) u_filt_b (
    .clock        (clock),
    .srst         (srst),
    .base_tick    (base_tick_reg),
    .smooth_sel   (smooth_sel_zone_b),
    .sample_valid (temp_valid),
    .sample       (temp_zone_b),
    .filt_temp    (filt_b)
  );

  // selected temperatures, refreshed every cycle; the valid comes one cycle before the new sample reaches them
  // limit checking downstream sees the new sample a cycle after the valid, in the cycle the boost logic evaluates it
  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl_valid_reg <= 1'b0;
      ctrl_a_reg     <= fbs_pkg::TEMP_RST;
      ctrl_b_reg     <= fbs_pkg::TEMP_RST;
      eval_reg       <= 1'b0;
    end else begin
      ctrl_valid_reg <= temp_valid;
      ctrl_a_reg     <= sel_a;
      ctrl_b_reg     <= sel_b;
      eval_reg       <= ctrl_valid_reg;
    end
  end

  // boost evaluated one cycle after the selected values settle
  // zones c and d have no smoothing here, so their raw readings drive boost directly
  fbs_boost_hyst #(
    .ZONES      (ZONES),
    .TEMP_W     (TEMP_W),
    .HYST_W     (HYST_W)
  ) u_boost (
    .clock      (clock),
    .srst       (srst),
    .eval       (eval_reg),
    .zone_temp  ({raw_d_reg, raw_c_reg, ctrl_b_reg, ctrl_a_reg}),
    .boost_temp (boost_temp_reg),
    .boost_hyst ({boost_hyst_zone_d, boost_hyst_zone_c, boost_hyst_zone_b, boost_hyst_zone_a}),
    .full_duty  (full_duty)
  );

  // outputs straight from flip-flops
  // full duty comes from the boost flip-flops inside the hysteresis module
  assign avs_readdata     = avs_readdata_reg;
  assign avs_waitrequest  = avs_waitrequest_reg;
  assign ctrl_temp_valid  = ctrl_valid_reg;
  assign ctrl_temp_zone_a = ctrl_a_reg;
  assign ctrl_temp_zone_b = ctrl_b_reg;
  assign pwm_full_duty    = full_duty;

endmodule // fbs_fan_boost_smooth

`default_nettype wire

/* File: test/fbs_monitor.sv */
/*
  fbs_monitor: port-level assertions for fbs_fan_boost_smooth.
  Assumes one clock domain and a synchronous active-high srst.
*/
`timescale 1ns/100ps
`default_nettype none

module fbs_monitor #(
  parameter int BASE_STEP_CYCLES = 4,
  parameter int TEMP_W           = 8
) (
  // clock and reset
  input wire logic        clock,
  input wire logic        srst,
  // register bus
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // temperature path
  input wire logic        temp_valid,
  input wire logic        ctrl_temp_valid,
  input wire logic [3:0]  pwm_full_duty
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  // bus answers after exactly one wait cycle, never unasked
  property p_wait_one;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest not low one cycle after request");
  property p_wait_cause;
    !avs_waitrequest |-> $past(avs_read || avs_write);
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("waitrequest low without request");
  property p_wait_short;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_short: assert property (p_wait_short) else $error("waitrequest low longer than one cycle");
  // a byte per word: upper read bits stay zero; data changes only with a read
  property p_rd_upper;
    avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits not zero");
  property p_rd_hold;
    !$stable(avs_readdata) |-> avs_read && !avs_waitrequest;
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data changed outside a read");
  // every converted sample yields one control pulse, a cycle later
  property p_ctrl_valid;
    temp_valid |=> ctrl_temp_valid;
  endproperty
  a_ctrl_valid: assert property (p_ctrl_valid) else $error("control valid missing after sample");
  property p_ctrl_lone;
    ctrl_temp_valid |-> $past(temp_valid);
  endproperty
  a_ctrl_lone: assert property (p_ctrl_lone) else $error("control valid without sample");
  // full duty only moves on an evaluation; the new level is first sampled three edges after the sample
  property p_pwm_cause;
    !$stable(pwm_full_duty) |-> $past(temp_valid, 3);
  endproperty
  a_pwm_cause: assert property (p_pwm_cause) else $error("full duty changed without evaluation");
  property p_reset;
    disable iff (1'b0) srst |=> avs_waitrequest && pwm_full_duty == 4'h0 && !ctrl_temp_valid;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not idle after reset");
endmodule // fbs_monitor

bind fbs_fan_boost_smooth fbs_monitor #(.BASE_STEP_CYCLES(BASE_STEP_CYCLES), .TEMP_W(TEMP_W)) fbs_monitor_inst (
  .clock(clock), .srst(srst), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .temp_valid(temp_valid), .ctrl_temp_valid(ctrl_temp_valid),
  .pwm_full_duty(pwm_full_duty));

`default_nettype wire

/* File: test/tb.sv */
/*
  tb: register, boost hysteresis and spike smoothing tests of fbs_fan_boost_smooth.
  Assumes a shortened filter base step so the shortest spans last a few hundred cycles.
*/
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic        clock;
  logic        srst;
  logic [9:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        temp_valid;
  logic [7:0]  temp_zone;
  logic        ctrl_temp_valid;
  logic [7:0]  ctrl_temp_zone_a;
  logic [7:0]  ctrl_temp_zone_b;
  logic [3:0]  pwm_full_duty;
  int          fails = 0;
  int          check_count = 0;
  int          cycles = 0;
  logic [31:0] rd;
  logic [31:0] ra;
  logic [31:0] rb;
  logic [3:0]  full;
  logic [7:0]  temps [9] = '{8'h31, 8'h30, 8'h2B, 8'h2A, 8'h22, 8'h21, 8'h20, 8'h31, 8'h1F};
  logic [3:0]  hyst  [4] = '{4'h5, 4'hF, 4'h0, 4'h9};

  // all four zones see the same temperature to keep the bench small
  fbs_fan_boost_smooth #(.BASE_STEP_CYCLES(4)) fbs_fan_boost_smooth_inst (
    .clock(clock), .srst(srst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .temp_valid(temp_valid), .temp_zone_a(temp_zone), .temp_zone_b(temp_zone), .temp_zone_c(temp_zone),
    .temp_zone_d(temp_zone), .ctrl_temp_valid(ctrl_temp_valid), .ctrl_temp_zone_a(ctrl_temp_zone_a),
    .ctrl_temp_zone_b(ctrl_temp_zone_b), .pwm_full_duty(pwm_full_duty));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // a hang counts as a mismatch
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails = fails + 1;
      final_report();
    end
  end

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // request held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge clock);
    avs_address   <= {idx, 2'h0};
    avs_read      <= ~wr;
    avs_write     <= wr;
    avs_writedata <= {24'h0, wd};
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(rd, {24'h0, exp});
  endtask

  // one-cycle sample pulse, then a gap above the three-cycle minimum
  task automatic sample(input logic [7:0] t, input int waits);
    @(posedge clock);
    temp_valid <= 1'b1;
    temp_zone  <= t;
    @(posedge clock);
    temp_valid <= 1'b0;
    repeat (waits) @(posedge clock);
  endtask

  task automatic do_reset;
    srst <= 1'b1;
    repeat (5) @(posedge clock);
    srst <= 1'b0;
  endtask

  initial begin
    srst = 1'b1;
    avs_address = 10'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    temp_valid = 1'b0;
    temp_zone = 8'h00;
    do_reset();
    // registers: reset values, read-back, unmapped place
    rdchk(fbs_pkg::IDX_HYST_AB, fbs_pkg::HYST_RST);
    rdchk(fbs_pkg::IDX_HYST_CD, fbs_pkg::HYST_RST);
    rdchk(fbs_pkg::IDX_SMOOTH_CTRL, fbs_pkg::SMOOTH_CTRL_RST);
    rdchk(fbs_pkg::IDX_BOOST_TEMP_A, fbs_pkg::BOOST_TEMP_RST);
    bus(1'b1, fbs_pkg::IDX_HYST_AB, 8'hF5);
    rdchk(fbs_pkg::IDX_HYST_AB, 8'hF5);
    bus(1'b1, fbs_pkg::IDX_HYST_CD, 8'h90);
    rdchk(fbs_pkg::IDX_HYST_CD, 8'h90);
    bus(1'b1, fbs_pkg::IDX_SMOOTH_CTRL, 8'hF7);
    rdchk(fbs_pkg::IDX_SMOOTH_CTRL, 8'hF7);
    bus(1'b1, fbs_pkg::IDX_SMOOTH_CTRL, 8'h00);
    bus(1'b1, 8'h10, 8'h5A);
    rdchk(8'h10, 8'h00);
    for (int z = 0; z < 4; z++) bus(1'b1, fbs_pkg::IDX_BOOST_TEMP_A + 8'(z), 8'h30);
    $display("test registers done");
    // boost set above 30h, released strictly below 30h minus each zone's hysteresis
    full = 4'h0;
    foreach (temps[i]) begin
      sample(temps[i], 4);
      for (int z = 0; z < 4; z++) begin
        if (temps[i] > 8'h30) full[z] = 1'b1;
        else if (temps[i] < 8'h30 - {4'h0, hyst[z]}) full[z] = 1'b0;
      end
      chk({28'h0, pwm_full_duty}, {28'h0, full});
      chk({24'h0, ctrl_temp_zone_a}, {24'h0, temps[i]});
    end
    $display("test boost done");
    // second reset so the first sample loads the filters
    do_reset();
    bus(1'b1, fbs_pkg::IDX_SMOOTH_CTRL, 8'h8F);
    sample(8'h10, 4);
    chk({24'h0, ctrl_temp_zone_a}, 32'h10);
    chk({24'h0, ctrl_temp_zone_b}, 32'h10);
    sample(8'h50, 300);
    bus(1'b0, fbs_pkg::IDX_FILT_TEMP_A, 8'h00);
    ra = rd;
    bus(1'b0, fbs_pkg::IDX_FILT_TEMP_B, 8'h00);
    rb = rd;
    rdchk(fbs_pkg::IDX_RAW_TEMP_A, 8'h50);
    rdchk(fbs_pkg::IDX_RAW_TEMP_B, 8'h50);
    // the shortest span must have moved further than the longest
    chk({31'h0, ra > rb}, 32'h1);
    chk({31'h0, ra < 32'h50}, 32'h1);
    chk({31'h0, ctrl_temp_zone_a >= ra[7:0] && ctrl_temp_zone_a < 8'h50}, 32'h1);
    // code 0 needs 118 base ticks per step, far more than this scenario has run
    chk({24'h0, ctrl_temp_zone_b}, 32'h10);
    chk(rb, 32'h10);
    bus(1'b1, fbs_pkg::IDX_SMOOTH_CTRL, 8'h07);
    repeat (3) @(posedge clock);
    chk({24'h0, ctrl_temp_zone_a}, 32'h50);
    chk({24'h0, ctrl_temp_zone_b}, 32'h50);
    bus(1'b0, fbs_pkg::IDX_FILT_TEMP_A, 8'h00);
    chk({31'h0, rd >= ra && rd < 32'h50}, 32'h1);
    // a falling input must pull the filter down, never past the new sample
    ra = rd;
    sample(8'h20, 40);
    bus(1'b0, fbs_pkg::IDX_FILT_TEMP_A, 8'h00);
    chk({31'h0, rd < ra && rd > 32'h20}, 32'h1);
    $display("test smoothing done");
    final_report();
  end
endmodule // tb

`default_nettype wire
